/* File: rtl/gsp_power_irq.sv */
// Power gating, latency tolerance, interrupt and error logic around a
// master-only serial host. Assumes the shift datapath, DMA engine and the
// driver's register file sit outside and talk through plain ports.
//
// Contract
// - While gated, each serial pin holds its latched idle level.
// - No edge or glitch on serial outputs during gate entry or exit.
// - Latency requirement goes to power controller over dedicated outputs.
// - Two tolerance schemes: hardware default or driver-set value.
// - Hardware scheme, active transfer: report rate-matched latency value.
// - Hardware scheme, idle: report no latency requirement.
// - One interrupt output signals the controller or DMA needs service.
// - Separate sticky status for host controller and for DMA.
// - Each pending bit clears only through its own unit's clear port.
// - Interrupt is active high, level, while any enabled bit pends.
// - Bus errors are detected and kept in readable sticky status.
// - FIFO threshold crossing raises interrupt or DMA request as enabled.
// - Controller is bus master, driving clock and chip select.
`timescale 1ns/1ps
module gsp_power_irq
    import gsp_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic                 core_sclk,
    input  wire logic                 core_cs_n,
    input  wire logic                 core_mosi,
    input  wire logic                 core_busy,
    input  wire logic                 pg_req,
    output logic                      pg_ack,
    output logic                      spi_sclk,
    output logic                      spi_cs_n,
    output logic                      spi_mosi,
    input  wire logic                 tol_sw_mode,
    input  wire logic                 tol_sw_req,
    input  wire logic [GSP_TOL_W-1:0] tol_sw_value,
    input  wire logic [GSP_TOL_W-1:0] tol_active_value,
    output logic [GSP_TOL_W-1:0]      latency_tolerance_report_value,
    output logic                      latency_tolerance_report_req,
    output logic                      latency_tolerance_report_update,
    input  wire logic [GSP_LVL_W-1:0] rx_level,
    input  wire logic [GSP_LVL_W-1:0] rx_thresh,
    input  wire logic [GSP_LVL_W-1:0] tx_level,
    input  wire logic [GSP_LVL_W-1:0] tx_thresh,
    input  wire logic                 dma_mode,
    output logic                      dma_rx_req,
    output logic                      dma_tx_req,
    input  wire logic [GSP_EVT_W-1:0] host_evt,
    input  wire logic [GSP_DMA_W-1:0] dma_evt,
    input  wire logic [GSP_HOST_W-1:0] host_en,
    input  wire logic [GSP_DMA_W-1:0] dma_en,
    input  wire logic [GSP_HOST_W-1:0] host_clr,
    input  wire logic [GSP_DMA_W-1:0] dma_clr,
    output logic [GSP_HOST_W-1:0]     host_stat,
    output logic [GSP_DMA_W-1:0]      dma_stat,
    input  wire logic                 rx_overrun,
    input  wire logic                 tx_underrun,
    input  wire logic [GSP_ERR_W-1:0] err_clr,
    output logic [GSP_ERR_W-1:0]      err_stat,
    output logic                      irq
);

    typedef struct packed {
        gsp_pwr_t              pwr;
        logic                  pg_ack;
        logic                  hold;
        logic                  latch;
        logic [GSP_TOL_W-1:0]  tol_value;
        logic                  tol_req;
        logic                  tol_update;
        logic                  rx_above;
        logic                  tx_below;
        logic                  dma_rx_req;
        logic                  dma_tx_req;
        logic [GSP_HOST_W-1:0] host_stat;
        logic [GSP_DMA_W-1:0]  dma_stat;
        logic [GSP_ERR_W-1:0]  err_stat;
        logic                  irq;
    } gsp_top_st_t;

    gsp_top_st_t st;
    gsp_top_st_t next_st;
    gsp_pin_if   pif ();

    // Set beats a clear arriving in the same cycle
    function automatic logic [GSP_HOST_W-1:0] sticky(
        input logic [GSP_HOST_W-1:0] cur,
        input logic [GSP_HOST_W-1:0] set,
        input logic [GSP_HOST_W-1:0] clr
    );
        return (cur & ~clr) | set;
    endfunction

    logic                  rx_hit;
    logic                  tx_hit;
    logic                  active;
    logic [GSP_ERR_W-1:0]  err_set;
    logic [GSP_HOST_W-1:0] host_set;
    logic [GSP_TOL_W-1:0]  tol_v;
    logic                  tol_r;

    always_comb
    begin
        next_st = st;
        next_st.latch = 1'b0;
        rx_hit = rx_level >= rx_thresh;
        tx_hit = tx_level <= tx_thresh;
        active = core_busy || !core_cs_n;

        case (st.pwr)
            GSP_ON:
            begin
                // Gate only when the bus is quiet
                if (pg_req && !core_busy && core_cs_n)
                begin
                    next_st.pwr   = GSP_GATING;
                    next_st.latch = 1'b1;
                    next_st.hold  = 1'b1;
                end
            end
            GSP_GATING:
            begin
                // Levels latched on the same edge that raises the ack
                next_st.pwr    = GSP_OFF;
                next_st.pg_ack = 1'b1;
            end
            GSP_OFF:
            begin
                if (!pg_req)
                begin
                    next_st.pwr    = GSP_WAKE;
                    next_st.pg_ack = 1'b0;
                end
            end
            GSP_WAKE:
            begin
                // Release only once the core matches the held levels
                if (pif.matched)
                begin
                    next_st.pwr  = GSP_ON;
                    next_st.hold = 1'b0;
                end
            end
            default:
            begin
                next_st.pwr = GSP_ON;
            end
        endcase

        // Tolerance scheme select
        if (tol_sw_mode)
        begin
            tol_v = tol_sw_value;
            tol_r = tol_sw_req;
        end
        else if (active && !st.hold)
        begin
            tol_v = tol_active_value;
            tol_r = 1'b1;
        end
        else
        begin
            tol_v = GSP_TOL_NONE;
            tol_r = 1'b0;
        end
        next_st.tol_value  = tol_v;
        next_st.tol_req    = tol_r;
        next_st.tol_update = (tol_v != st.tol_value) || (tol_r != st.tol_req);

        // Threshold crossing: interrupt or DMA request
        next_st.rx_above   = rx_hit;
        next_st.tx_below   = tx_hit;
        next_st.dma_rx_req = dma_mode && rx_hit;
        next_st.dma_tx_req = dma_mode && tx_hit;

        // Bus errors, including select driven while gated
        err_set = '0;
        err_set[GSP_ERR_RX_OVR] = rx_overrun;
        err_set[GSP_ERR_TX_UND] = tx_underrun;
        err_set[GSP_ERR_GATED]  = st.hold && !core_cs_n;
        next_st.err_stat = (st.err_stat & ~err_clr) | err_set;

        host_set = '0;
        host_set[GSP_HST_RX_THR] = !dma_mode && rx_hit && !st.rx_above;
        host_set[GSP_HST_TX_THR] = !dma_mode && tx_hit && !st.tx_below;
        host_set[GSP_HST_BUSERR] = |err_set;
        host_set[GSP_HOST_W-1:GSP_HST_EVT_LO] = host_evt;

        // Each unit cleared only by its own clear port
        next_st.host_stat = sticky(st.host_stat, host_set, host_clr);
        next_st.dma_stat  = sticky(st.dma_stat, dma_evt, dma_clr);

        // Level interrupt from enabled pending bits
        next_st.irq = |(next_st.host_stat & host_en)
                   || |(next_st.dma_stat & dma_en);
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '{GSP_ON, 1'b0, 1'b0, 1'b0, GSP_TOL_NONE, 1'b0, 1'b0,
                    1'b0, 1'b0, 1'b0, 1'b0, '0, '0, '0, 1'b0};
        else
            st <= next_st;
    end

    assign pif.core_sclk = core_sclk;
    assign pif.core_cs_n = core_cs_n;
    assign pif.core_mosi = core_mosi;
    assign pif.hold      = st.hold;
    assign pif.latch     = st.latch;

    gsp_pin_hold u_pins (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .pif      (pif),
        .spi_sclk (spi_sclk),
        .spi_cs_n (spi_cs_n),
        .spi_mosi (spi_mosi)
    );

    assign pg_ack                          = st.pg_ack;
    assign latency_tolerance_report_value  = st.tol_value;
    assign latency_tolerance_report_req    = st.tol_req;
    assign latency_tolerance_report_update = st.tol_update;
    assign dma_rx_req                      = st.dma_rx_req;
    assign dma_tx_req                      = st.dma_tx_req;
    assign host_stat                       = st.host_stat;
    assign dma_stat                        = st.dma_stat;
    assign err_stat                        = st.err_stat;
    assign irq                             = st.irq;

endmodule // gsp_power_irq

/* File: rtl/gsp_pkg.sv */
// Shared constants and types for the serial host power, tolerance and
// interrupt wrapper. Assumes one 200 MHz clock and active-low async reset.
package gsp_pkg;

    localparam int GSP_HOST_W = 8;
    localparam int GSP_DMA_W  = 8;
    localparam int GSP_ERR_W  = 3;
    localparam int GSP_TOL_W  = 16;
    localparam int GSP_LVL_W  = 7;
    localparam int GSP_EVT_W  = 5;

    // Host status bit positions
    localparam int GSP_HST_RX_THR = 0;
    localparam int GSP_HST_TX_THR = 1;
    localparam int GSP_HST_BUSERR = 2;
    localparam int GSP_HST_EVT_LO = 3;

    // Error status bit positions
    localparam int GSP_ERR_RX_OVR = 0;
    localparam int GSP_ERR_TX_UND = 1;
    localparam int GSP_ERR_GATED  = 2;

    // Pin levels after reset: bus idle, chip select deasserted
    localparam logic GSP_RST_SCLK = 1'h0;
    localparam logic GSP_RST_CS_N = 1'h1;
    localparam logic GSP_RST_MOSI = 1'h0;

    localparam logic [GSP_TOL_W-1:0] GSP_TOL_NONE = 16'h0000;

    typedef enum logic [3:0] {
        GSP_ON     = 4'h1,
        GSP_GATING = 4'h2,
        GSP_OFF    = 4'h4,
        GSP_WAKE   = 4'h8
    } gsp_pwr_t;

endpackage

/* File: rtl/gsp_pin_if.sv */
// Carries the core's pin levels and the hold controls to the pin stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface gsp_pin_if;
    logic core_sclk;
    logic core_cs_n;
    logic core_mosi;
    logic hold;
    logic latch;
    logic matched;

    modport ctrl (output core_sclk, core_cs_n, core_mosi, hold, latch,
                  input  matched);
    modport pins (input  core_sclk, core_cs_n, core_mosi, hold, latch,
                  output matched);
endinterface

/* File: rtl/gsp_pin_hold.sv */
// Pin stage: registers the serial pins and freezes them at latched idle
// levels while held. Assumes latch is pulsed only while the bus is idle.
`timescale 1ns/1ps
module gsp_pin_hold
    import gsp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    gsp_pin_if.pins   pif,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi
);

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
        logic idle_sclk;
        logic idle_cs_n;
        logic idle_mosi;
        logic matched;
    } gsp_pin_st_t;

    gsp_pin_st_t st;
    gsp_pin_st_t next_st;

    always_comb
    begin
        next_st = st;
        if (pif.latch)
        begin
            next_st.idle_sclk = pif.core_sclk;
            next_st.idle_cs_n = pif.core_cs_n;
            next_st.idle_mosi = pif.core_mosi;
        end
        // Held pins follow the core only in the latch cycle, then keep the idle levels, so no edge leaks out
        if (pif.hold || pif.latch)
        begin
            next_st.sclk = pif.latch ? pif.core_sclk : st.idle_sclk;
            next_st.cs_n = pif.latch ? pif.core_cs_n : st.idle_cs_n;
            next_st.mosi = pif.latch ? pif.core_mosi : st.idle_mosi;
        end
        else
        begin
            // Master drives clock and select itself
            next_st.sclk = pif.core_sclk;
            next_st.cs_n = pif.core_cs_n;
            next_st.mosi = pif.core_mosi;
        end
        next_st.matched = (pif.core_sclk == st.idle_sclk)
                       && (pif.core_cs_n == st.idle_cs_n)
                       && (pif.core_mosi == st.idle_mosi);
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '{GSP_RST_SCLK, GSP_RST_CS_N, GSP_RST_MOSI,
                    GSP_RST_SCLK, GSP_RST_CS_N, GSP_RST_MOSI, 1'b1};
        else
            st <= next_st;
    end

    assign spi_sclk    = st.sclk;
    assign spi_cs_n    = st.cs_n;
    assign spi_mosi    = st.mosi;
    assign pif.matched = st.matched;

endmodule // gsp_pin_hold

/* File: bench/gsp_periph.sv */
// Far-side serial peripheral: shifts in one byte while selected.
// Assumes bus mode 0, most significant bit first.
`timescale 1ns/1ps
module gsp_periph (
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    input  wire logic       low_power,
    output logic [15:0]     edges,
    output logic [7:0]      rx_byte
);
    initial edges = 16'h0000;
    initial rx_byte = 8'h00;
    // Counts even zero-width glitches, which a clocked sampler would miss
    always @(spi_sclk or spi_cs_n or spi_mosi)
        edges <= edges + 16'h0001;
    // The part shifts in data only while selected and not in low power
    always @(posedge spi_sclk)
        if (!spi_cs_n && !low_power)
            rx_byte <= {rx_byte[6:0], spi_mosi};
endmodule // gsp_periph

/* File: bench/gsp_props_properties.sv */
// Concurrent checks on the ports of the power, tolerance and irq block.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
module gsp_props
    import gsp_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        core_busy,
    input wire logic        core_cs_n,
    input wire logic        pg_req,
    input wire logic        pg_ack,
    input wire logic        spi_sclk,
    input wire logic        spi_cs_n,
    input wire logic        spi_mosi,
    input wire logic        tol_sw_mode,
    input wire logic [15:0] latency_tolerance_report_value,
    input wire logic        latency_tolerance_report_req,
    input wire logic [6:0]  rx_level,
    input wire logic [6:0]  rx_thresh,
    input wire logic        dma_mode,
    input wire logic        dma_rx_req,
    input wire logic [7:0]  dma_evt,
    input wire logic [7:0]  host_en,
    input wire logic [7:0]  dma_en,
    input wire logic [7:0]  dma_clr,
    input wire logic [7:0]  host_stat,
    input wire logic [7:0]  dma_stat,
    input wire logic        rx_overrun,
    input wire logic [2:0]  err_stat,
    input wire logic        irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_gated_pins_hold: assert property (
        pg_ack && $past(pg_ack) |-> $stable({spi_sclk, spi_cs_n, spi_mosi}))
        else $error("pins moved while gated");
    a_gate_when_idle: assert property (
        $rose(pg_ack) |-> $past(pg_req, 2) && !$past(core_busy, 2)
        && $past(core_cs_n, 2)) else $error("gate taken while busy");
    a_gated_cs_off: assert property (pg_ack |-> spi_cs_n)
        else $error("select asserted while gated");
    a_tol_idle_none: assert property (
        !tol_sw_mode && !core_busy && core_cs_n |=>
        latency_tolerance_report_value == GSP_TOL_NONE
        && !latency_tolerance_report_req) else $error("idle tolerance wrong");
    a_irq_level_or: assert property (
        irq == |{host_stat & $past(host_en), dma_stat & $past(dma_en)})
        else $error("irq level wrong");
    a_dma_stat_sticky: assert property (
        1'h1 |=> dma_stat == (($past(dma_stat) & ~$past(dma_clr))
        | $past(dma_evt))) else $error("dma status wrong");
    a_dma_rx_thr: assert property (
        dma_mode && rx_level >= rx_thresh |=> dma_rx_req)
        else $error("dma rx request missing");
    a_err_rx_flag: assert property (
        rx_overrun |=> err_stat[0] && host_stat[2])
        else $error("overrun not recorded");
    c_gate: cover property ($rose(pg_ack));
    c_irq: cover property ($rose(irq));
    c_dma: cover property ($rose(dma_rx_req));
endmodule // gsp_props
bind gsp_power_irq gsp_props gsp_props_inst (.*);

/* File: bench/tb.sv */
// Self-checking bench for the power, tolerance and irq block.
// Assumes the peripheral model sits on the serial pins.
`timescale 1ns/1ps
module tb;
    import gsp_pkg::*;
    logic ref_clk = 1'h0, nrst = 1'h0, low_power = 1'h0;
    logic core_sclk = 1'h0, core_cs_n = 1'h1, core_mosi = 1'h0;
    logic core_busy = 1'h0, pg_req = 1'h0, dma_mode = 1'h0;
    logic tol_sw_mode = 1'h0, tol_sw_req = 1'h0;
    logic rx_overrun = 1'h0, tx_underrun = 1'h0;
    logic [15:0] tol_sw_value = 16'h0000, tol_active_value = 16'h0000;
    logic [6:0] rx_level = 7'h00, rx_thresh = 7'h08;
    logic [6:0] tx_level = 7'h20, tx_thresh = 7'h04;
    logic [4:0] host_evt = 5'h00;
    logic [7:0] dma_evt = 8'h00, host_en = 8'h00, dma_en = 8'h00;
    logic [7:0] host_clr = 8'h00, dma_clr = 8'h00;
    logic [2:0] err_clr = 3'h0;
    logic pg_ack, spi_sclk, spi_cs_n, spi_mosi, irq, dma_rx_req, dma_tx_req;
    logic [15:0] latency_tolerance_report_value, edges;
    logic latency_tolerance_report_req, latency_tolerance_report_update;
    logic [7:0] host_stat, dma_stat, rx_byte;
    logic [2:0] err_stat;
    int err_count = 0, total_checks = 0;
    gsp_power_irq gsp_power_irq_inst (.*);
    gsp_periph gsp_periph_inst (.*);
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // Lands after the edges so registered outputs have settled
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic t_gate();
        logic [15:0] base;
        @(posedge ref_clk);
        pg_req <= 1'h1;
        low_power <= 1'h1;
        wt(2);
        chk(pg_ack, 1'h1);
        base = edges;
        repeat (4)
        begin
            @(posedge ref_clk);
            core_sclk <= ~core_sclk;
            core_mosi <= ~core_mosi;
            core_cs_n <= 1'h0;
        end
        wt(1);
        chk(edges, base);
        chk(err_stat[2], 1'h1);
        @(posedge ref_clk);
        core_cs_n <= 1'h1;
        pg_req <= 1'h0;
        low_power <= 1'h0;
        err_clr <= 3'h7;
        host_clr <= 8'h04;
        @(posedge ref_clk);
        err_clr <= 3'h0;
        host_clr <= 8'h00;
        wt(8);
        chk(pg_ack, 1'h0);
        chk(edges, base);
        chk(err_stat, 3'h0);
        @(posedge ref_clk);
        core_busy <= 1'h1;
        pg_req <= 1'h1;
        wt(4);
        chk(pg_ack, 1'h0);
        @(posedge ref_clk);
        pg_req <= 1'h0;
        core_busy <= 1'h0;
    endtask
    task automatic t_tol();
        @(posedge ref_clk);
        tol_sw_mode <= 1'h1;
        tol_sw_value <= 16'h1234;
        tol_sw_req <= 1'h1;
        wt(1);
        chk(latency_tolerance_report_value, 16'h1234);
        chk(latency_tolerance_report_update, 1'h1);
        chk(latency_tolerance_report_req, 1'h1);
        @(posedge ref_clk);
        tol_sw_mode <= 1'h0;
        core_busy <= 1'h1;
        tol_active_value <= 16'h0050;
        wt(1);
        chk(latency_tolerance_report_value, 16'h0050);
        chk(latency_tolerance_report_req, 1'h1);
        @(posedge ref_clk);
        core_busy <= 1'h0;
        wt(1);
        chk(latency_tolerance_report_value, GSP_TOL_NONE);
        chk(latency_tolerance_report_req, 1'h0);
        chk(latency_tolerance_report_update, 1'h1);
        // No change taken on this edge, so the pulse must have ended
        wt(1);
        chk(latency_tolerance_report_update, 1'h0);
    endtask
    task automatic t_irq();
        @(posedge ref_clk);
        host_en <= 8'h08;
        host_evt <= 5'h01;
        dma_evt <= 8'h04;
        @(posedge ref_clk);
        host_evt <= 5'h00;
        dma_evt <= 8'h00;
        dma_clr <= 8'h08;
        wt(0);
        chk({host_stat, dma_stat}, 16'h0804);
        chk(irq, 1'h1);
        @(posedge ref_clk);
        dma_clr <= 8'h00;
        host_clr <= 8'h08;
        wt(0);
        chk(host_stat[3], 1'h1);
        @(posedge ref_clk);
        host_clr <= 8'h00;
        dma_en <= 8'h04;
        wt(0);
        chk({host_stat[3], irq}, 2'h0);
        wt(1);
        chk(irq, 1'h1);
        @(posedge ref_clk);
        dma_clr <= 8'h04;
        @(posedge ref_clk);
        dma_clr <= 8'h00;
        wt(0);
        chk({dma_stat, 7'h00, irq}, 16'h0000);
    endtask
    task automatic t_thr();
        @(posedge ref_clk);
        rx_level <= 7'h08;
        wt(1);
        chk({host_stat[1:0], dma_rx_req}, 3'h2);
        @(posedge ref_clk);
        host_clr <= 8'h01;
        dma_mode <= 1'h1;
        tx_level <= 7'h04;
        @(posedge ref_clk);
        host_clr <= 8'h00;
        wt(0);
        chk({host_stat[1:0], dma_rx_req, dma_tx_req}, 4'h3);
        @(posedge ref_clk);
        dma_mode <= 1'h0;
        rx_level <= 7'h00;
        tx_level <= 7'h20;
    endtask
    task automatic t_err();
        @(posedge ref_clk);
        rx_overrun <= 1'h1;
        tx_underrun <= 1'h1;
        @(posedge ref_clk);
        rx_overrun <= 1'h0;
        tx_underrun <= 1'h0;
        wt(0);
        chk({err_stat, host_stat[2]}, 4'h7);
    endtask
    task automatic t_bus();
        logic [7:0] b;
        b = 8'hA5;
        @(posedge ref_clk);
        core_cs_n <= 1'h0;
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge ref_clk);
            core_mosi <= b[i];
            core_sclk <= 1'h0;
            @(posedge ref_clk);
            core_sclk <= 1'h1;
        end
        @(posedge ref_clk);
        core_sclk <= 1'h0;
        core_cs_n <= 1'h1;
        wt(2);
        chk({rx_byte, 7'h00, spi_cs_n}, 16'hA501);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'h1;
        wt(1);
        t_gate();
        t_tol();
        t_irq();
        t_thr();
        t_err();
        t_bus();
        end_of_test();
    end
endmodule // tb
